// [core/rtc_pkg.sv]
// Purpose: Shared constants and types of the calendar, trim and alarm block.
// Assumes: A 100 MHz system clock and a 32.768 kHz crystal input.
// Notes:   Offsets are register indices on the internal register port.
package rtc_pkg;

   // ***************************************************************
   // Register offsets
   // ***************************************************************
   localparam logic [3:0] OFS_WEEKDAY = 4'h3;  // Weekday counter.
   localparam logic [3:0] OFS_DATE    = 4'h4;  // Date_count.
   localparam logic [3:0] OFS_MONTH   = 4'h5;  // Month and century bit.
   localparam logic [3:0] OFS_YEAR    = 4'h6;  // Year counter.
   localparam logic [3:0] OFS_TRIM    = 4'h7;  // Second length trim.
   localparam logic [3:0] OFS_AMIN    = 4'h8;  // Weekly alarm minute.
   localparam logic [3:0] OFS_AHOUR   = 4'h9;  // Weekly alarm hour.

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int CENTURY_BIT = 7;             // Century bit in month reg.
   localparam int TRIM_SIGN   = 6;             // Sign bit of trim code.

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [2:0] WEEKDAY_RST = 3'h0;  // Weekday after reset.
   localparam logic [5:0] DATE_RST    = 6'h01; // Day-of-month after reset.
   localparam logic [4:0] MONTH_RST   = 5'h01; // Month after reset.
   localparam logic [7:0] YEAR_RST    = 8'h00; // Year after reset.
   localparam logic [6:0] TRIM_RST    = 7'h00; // Trim after reset.
   localparam logic [6:0] AMIN_RST    = 7'h00; // Alarm minute after reset.
   localparam logic [5:0] AHOUR_RST   = 6'h00; // Alarm hour after reset.

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam logic [15:0] SEC_NOMINAL   = 16'h8000; // Crystal ticks/second.
   localparam int          CLK_PERIOD_NS = 10;       // System clock period.
   localparam int          ALARM_DELAY_NS = 61000;   // Alarm flag delay.
   localparam int ALARM_DELAY_CYC =
      (ALARM_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ***************************************************************
   // Carrier types
   // ***************************************************************
   typedef struct packed {
      logic       wr;                          // One-cycle write strobe.
      logic [3:0] addr;                        // Register index.
      logic [7:0] data;                        // Write data.
   } rtc_req_s;

   typedef struct packed {
      logic [6:0] sec;                         // BCD seconds.
      logic [6:0] min;                         // BCD minutes.
      logic [5:0] hour;                        // BCD hour, bit 5 PM or 20.
   } rtc_tod_s;

endpackage

// [core/rtc_cal_trim.sv]
// Purpose: Weekday, date, month, century and year counters, the one-second
//          divider with its twenty-second trim, and the weekly alarm time.
// Assumes: Register port and time of day come from logic on CLK.
// Notes:   The crystal arrives as a pin and is synchronised here.
// Contract
// - Weekday steps once per day carry.
// - Weekday counts 0 to 6 then wraps.
// - Weekday codes carry no fixed meaning.
// - Day limit follows month and leap year.
// - After last day, date to 1, month advances.
// - Month counts 1 to 12, wrap advances year.
// - Year counts 00 to 99 and wraps.
// - Years divisible by four are leap years.
// - Century bit toggles on year wrap.
// - Nominal second is 32768 crystal ticks.
// - Trim applies only at seconds 00, 20, 40.
// - Positive code n adds 2(n-1) ticks.
// - Code one means no correction.
// - Negative code shortens second by 2|n|.
// - Trim write activates; same-point write skipped.
// - Power-on flag clears the trim register.
// - Day carry comes from hour rollover.
// - Alarm hour bit 5 is PM or twenties.
// - Weekly alarm hit about 61 us after match.
`timescale 1ns/1ns
module rtc_cal_trim #(
   parameter int ALARM_DELAY_CYC = rtc_pkg::ALARM_DELAY_CYC // Alarm delay.
) (
   input  wire logic             CLK,          // System clock, 100 MHz.
   input  wire logic             RST_N,        // Asynchronous reset, low.
   input  wire logic             XTAL_CLK,     // Crystal clock pin.
   input  wire rtc_pkg::rtc_req_s REG_REQ,     // Register write request.
   input  wire logic [3:0]       REG_RADDR,    // Register read index.
   output logic      [7:0]       REG_RDATA,    // Read data, one cycle late.
   input  wire logic             POWERON_FLAG,          // Power-on flag level.
   input  wire logic             DIV_CLEAR,    // Seconds write pulse.
   input  wire logic             DAY_CARRY,    // Hour rollover pulse.
   input  wire rtc_pkg::rtc_tod_s TOD,         // Current time of day.
   input  wire logic             WEEKLY_ALARM_ENABLE,         // Weekly alarm enable.
   input  wire logic [6:0]       WALARM_DAYS,  // Weekly alarm day mask.
   output logic                  SEC_TICK,     // One-second pulse.
   output logic                  WALARM_HIT    // Weekly alarm set pulse.
);

   // ***************************************************************
   // Helper functions
   // ***************************************************************
   // Adds one to a two-digit BCD value.
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   // Last valid day of a BCD month.
   function automatic logic [5:0] last_day(input logic [4:0] m,
                                           input logic       leap);
      case (m)
         5'h02: last_day = leap ? 6'h29 : 6'h28;
         5'h04, 5'h06, 5'h09, 5'h11: last_day = 6'h30;
         default: last_day = 6'h31;
      endcase
   endfunction

   // Length of an adjusted second in crystal ticks for a trim code.
   function automatic logic [15:0] trim_len(input logic [6:0] t);
      // A negative code takes 256 off: 32768 + 2t - 256 = 32768 - 2|n|.
      if (t == 7'h00) begin
         trim_len = rtc_pkg::SEC_NOMINAL;
      end else begin
         trim_len = rtc_pkg::SEC_NOMINAL + {8'h00, t, 1'b0} -
                    (t[rtc_pkg::TRIM_SIGN] ? 16'h0100 : 16'h0002);
      end
   endfunction

   // ***************************************************************
   // Storage
   // ***************************************************************
   logic [2:0]  weekday;          // Weekday code.
   logic [5:0]  date;             // BCD day of month.
   logic [4:0]  month;            // BCD month.
   logic        century;          // Century bit.
   logic [7:0]  year;             // BCD year.
   logic [6:0]  trim;             // Trim code.
   logic        trim_active;      // Adjustment switched on by a write.
   logic        trim_skip;        // Current adjust point was written.
   logic [6:0]  amin;             // Weekly alarm minute.
   logic [5:0]  ahour;            // Weekly alarm hour.
   logic        xs1;              // Crystal synchroniser, first stage.
   logic        xs2;              // Crystal synchroniser, second stage.
   logic        xs3;              // Delayed copy for edge finding.
   logic [15:0] div_cnt;          // Crystal ticks in current second.
   logic        match_q;          // Alarm match in the previous cycle.
   logic        alarm_run;        // Alarm delay in progress.
   logic [12:0] alarm_cnt;        // Alarm delay counter.

   // ***************************************************************
   // Decode
   // ***************************************************************
   wire wr = REG_REQ.wr;                                  // Write strobe.
   wire wr_weekday = wr && (REG_REQ.addr == rtc_pkg::OFS_WEEKDAY);
   wire wr_date    = wr && (REG_REQ.addr == rtc_pkg::OFS_DATE);
   wire wr_month   = wr && (REG_REQ.addr == rtc_pkg::OFS_MONTH);
   wire wr_year    = wr && (REG_REQ.addr == rtc_pkg::OFS_YEAR);
   wire wr_trim    = wr && (REG_REQ.addr == rtc_pkg::OFS_TRIM);
   wire wr_amin    = wr && (REG_REQ.addr == rtc_pkg::OFS_AMIN);
   wire wr_ahour   = wr && (REG_REQ.addr == rtc_pkg::OFS_AHOUR);

   // Leap year when the BCD year is a multiple of four, 00 included.
   wire leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                       : (year[3:0] == 4'h0 || year[3:0] == 4'h4 ||
                          year[3:0] == 4'h8);

   // Calendar carries, all driven by the day carry from the hour counter.
   wire        month_end  = (date == last_day(month, leap));
   wire        year_step  = DAY_CARRY && month_end &&
                            (month == 5'h12);
   wire        year_wrap  = year_step && (year == 8'h99);
   wire [7:0]  date_inc   = bcd_inc({2'h0, date});
   wire [7:0]  month_inc  = bcd_inc({3'h0, month});
   wire [2:0]  next_weekday = (weekday == 3'h6) ? 3'h0
                              : weekday + 3'h1;
   wire [5:0]  next_date  = month_end ? 6'h01 : date_inc[5:0];
   wire [4:0]  next_month = (month == 5'h12) ? 5'h01
                            : month_inc[4:0];
   wire [7:0]  next_year  = year_wrap ? 8'h00 : bcd_inc(year);

   // Crystal edge and second divider.
   wire        xtal_edge  = xs2 && !xs3;
   wire        sec_point  = (TOD.sec == 7'h00) || (TOD.sec == 7'h20) ||
                            (TOD.sec == 7'h40);
   wire        adjusted   = trim_active && sec_point && !trim_skip;
   wire [15:0] sec_len    = adjusted ? trim_len(trim)
                                     : rtc_pkg::SEC_NOMINAL;
   wire        sec_end    = xtal_edge &&
                            (div_cnt >= sec_len - 16'h0001);

   // Weekly alarm match; the hour holds bit 5 as PM or twenties, so the
   // comparison is bit for bit in either hour mode.
   wire day_hit = (weekday != 3'h7) && WALARM_DAYS[weekday];
   wire match   = WEEKLY_ALARM_ENABLE && day_hit && (TOD.min == amin) &&
                  (TOD.hour == ahour);

   // Read selection; unused bit positions read as zero.
   logic [7:0] rd_mux;            // Selected read value.
   always_comb begin
      case (REG_RADDR)
         rtc_pkg::OFS_WEEKDAY: rd_mux = {5'h00, weekday};
         rtc_pkg::OFS_DATE:    rd_mux = {2'h0, date};
         rtc_pkg::OFS_MONTH:   rd_mux = {century, 2'h0, month};
         rtc_pkg::OFS_YEAR:    rd_mux = year;
         rtc_pkg::OFS_TRIM:    rd_mux = {1'b0, trim};
         rtc_pkg::OFS_AMIN:    rd_mux = {1'b0, amin};
         rtc_pkg::OFS_AHOUR:   rd_mux = {2'h0, ahour};
         default:              rd_mux = 8'h00;
      endcase
   end

   // ***************************************************************
   // Calendar counters
   // ***************************************************************
   // Weekday: a write wins, otherwise step on the day carry.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         weekday <= rtc_pkg::WEEKDAY_RST;
      end else if (wr_weekday) begin
         weekday <= REG_REQ.data[2:0];
      end else if (DAY_CARRY) begin
         weekday <= next_weekday;
      end
   end

   // Day of month: reset to one after the last day of the month.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         date <= rtc_pkg::DATE_RST;
      end else if (wr_date) begin
         date <= REG_REQ.data[5:0];
      end else if (DAY_CARRY) begin
         date <= next_date;
      end
   end

   // Month and century bit.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         month   <= rtc_pkg::MONTH_RST;
         century <= 1'b0;
      end else if (wr_month) begin
         month   <= REG_REQ.data[4:0];
         century <= REG_REQ.data[rtc_pkg::CENTURY_BIT];
      end else begin
         if (DAY_CARRY && month_end) begin
            month <= next_month;
         end
         if (year_wrap) begin
            century <= !century;
         end
      end
   end

   // Year, stepped when the month wraps from 12 to 1.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         year <= rtc_pkg::YEAR_RST;
      end else if (wr_year) begin
         year <= REG_REQ.data;
      end else if (year_step) begin
         year <= next_year;
      end
   end

   // ***************************************************************
   // Trim register and activation
   // ***************************************************************
   // Power-on flag clears the trim and switches the adjustment off.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         trim        <= rtc_pkg::TRIM_RST;
         trim_active <= 1'b0;
      end else if (POWERON_FLAG) begin
         trim        <= rtc_pkg::TRIM_RST;
         trim_active <= 1'b0;
      end else if (wr_trim) begin
         trim        <= REG_REQ.data[6:0];
         trim_active <= 1'b1;
      end
   end

   // A write during an adjust point keeps that second nominal; the set
   // wins over the clear at the end of the second.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         trim_skip <= 1'b0;
      end else if (wr_trim && sec_point) begin
         trim_skip <= 1'b1;
      end else if (sec_end || DIV_CLEAR) begin
         trim_skip <= 1'b0;
      end
   end

   // ***************************************************************
   // Crystal synchroniser and second divider
   // ***************************************************************
   // Two flip-flops bring the crystal in; the third finds rising edges.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         xs1 <= 1'b0;
         xs2 <= 1'b0;
         xs3 <= 1'b0;
      end else begin
         xs1 <= XTAL_CLK;
         xs2 <= xs1;
         xs3 <= xs2;
      end
   end

   // Counts crystal edges; ends the second at the selected length.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         div_cnt  <= 16'h0000;
         SEC_TICK <= 1'b0;
      end else begin
         SEC_TICK <= sec_end && !DIV_CLEAR;
         if (DIV_CLEAR || sec_end) begin
            div_cnt <= 16'h0000;
         end else if (xtal_edge) begin
            div_cnt <= div_cnt + 16'h0001;
         end
      end
   end

   // ***************************************************************
   // Weekly alarm time and delayed hit
   // ***************************************************************
   // Alarm minute and hour registers.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         amin  <= rtc_pkg::AMIN_RST;
         ahour <= rtc_pkg::AHOUR_RST;
      end else begin
         if (wr_amin) begin
            amin <= REG_REQ.data[6:0];
         end
         if (wr_ahour) begin
            ahour <= REG_REQ.data[5:0];
         end
      end
   end

   // A new match starts the delay; the hit pulses when it runs out, and
   // is dropped if the alarm is disabled meanwhile.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         match_q    <= 1'b0;
         alarm_run  <= 1'b0;
         alarm_cnt  <= 13'h0000;
         WALARM_HIT <= 1'b0;
      end else begin
         match_q    <= match;
         WALARM_HIT <= 1'b0;
         if (match && !match_q) begin
            alarm_run <= 1'b1;
            alarm_cnt <= 13'h0000;
         end else if (alarm_run && !WEEKLY_ALARM_ENABLE) begin
            alarm_run <= 1'b0;
         end else if (alarm_run) begin
            if (alarm_cnt == 13'(ALARM_DELAY_CYC - 1)) begin
               alarm_run  <= 1'b0;
               WALARM_HIT <= 1'b1;
            end else begin
               alarm_cnt <= alarm_cnt + 13'h0001;
            end
         end
      end
   end

   // ***************************************************************
   // Read data register
   // ***************************************************************
   // Read data follows the read index one cycle later.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         REG_RDATA <= 8'h00;
      end else begin
         REG_RDATA <= rd_mux;
      end
   end

endmodule // rtc_cal_trim

// [bench/rtc_cal_trim_props.sv]
// Purpose: Port checks of the calendar, trim and alarm block.
// Assumes: One clock domain; a read answers one edge after its index.
// Notes:   Bound to every rtc_cal_trim instance.
`timescale 1ns/1ns
module rtc_cal_trim_props #(
   parameter int ALARM_DELAY_CYC = 4            // Alarm delay in cycles.
) (
   input wire logic              CLK,           // System clock.
   input wire logic              RST_N,         // Reset, active low.
   input wire logic              XTAL_CLK,      // Crystal pin.
   input wire rtc_pkg::rtc_req_s REG_REQ,       // Write request.
   input wire logic [3:0]        REG_RADDR,     // Read index.
   input wire logic [7:0]        REG_RDATA,     // Read data.
   input wire logic              POWERON_FLAG,           // Power-on flag.
   input wire logic              DIV_CLEAR,     // Divider clear.
   input wire logic              DAY_CARRY,     // Day carry pulse.
   input wire logic              WEEKLY_ALARM_ENABLE,          // Alarm enable.
   input wire logic [6:0]        WALARM_DAYS,   // Alarm day mask.
   input wire logic              SEC_TICK,      // Second pulse.
   input wire logic              WALARM_HIT     // Alarm pulse.
);
   // ***************************************************************
   // Helper logic
   // ***************************************************************
   logic [7:0]  unused_mask;                    // Bits that read zero.
   logic [2:0]  xsync;                          // Crystal sampling chain.
   logic [16:0] xcnt;                           // Crystal edges counted.
   wire         xrise = xsync[1] & ~xsync[2];   // Crystal rising edge.
   assign unused_mask = (REG_RADDR < rtc_pkg::OFS_WEEKDAY ||
                         REG_RADDR > rtc_pkg::OFS_AHOUR) ? 8'hff :
                        8'(56'hc0808000_60c0f8 >>
                           8 * (REG_RADDR - rtc_pkg::OFS_WEEKDAY));
   // Next BCD value; 99 folds to 00.
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v == 8'h99) return 8'h00;
      return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
   endfunction
   // Crystal sampled as the block does it.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) xsync <= 3'h0;
      else xsync <= {xsync[1:0], XTAL_CLK};
   end
   // Crystal edges since the last tick or clear.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) xcnt <= 17'h0;
      else if (SEC_TICK || DIV_CLEAR) xcnt <= 17'h0;
      else xcnt <= xcnt + {16'h0, xrise};
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // ***************************************************************
   // Assertions
   // ***************************************************************
   unused_bits_a: assert property (
      1'b1 |=> (REG_RDATA & $past(unused_mask)) == 8'h00)
      else $error("unused bits set");
   wd_step_a: assert property (
      DAY_CARRY && !REG_REQ.wr && REG_RADDR == rtc_pkg::OFS_WEEKDAY
      ##1 REG_RADDR == rtc_pkg::OFS_WEEKDAY |=> REG_RDATA ==
      (($past(REG_RDATA) >= 8'h06) ? 8'h00 : $past(REG_RDATA) + 8'h01))
      else $error("weekday step wrong");
   date_step_a: assert property (
      DAY_CARRY && !REG_REQ.wr && REG_RADDR == rtc_pkg::OFS_DATE
      ##1 REG_RADDR == rtc_pkg::OFS_DATE |=> REG_RDATA == 8'h01 ||
      REG_RDATA == bcd_inc($past(REG_RDATA)))
      else $error("date step wrong");
   year_step_a: assert property (
      DAY_CARRY && !REG_REQ.wr && REG_RADDR == rtc_pkg::OFS_YEAR
      ##1 REG_RADDR == rtc_pkg::OFS_YEAR |=> REG_RDATA == $past(REG_RDATA)
      || REG_RDATA == bcd_inc($past(REG_RDATA)))
      else $error("year step wrong");
   date_range_a: assert property (
      $past(REG_RADDR) == rtc_pkg::OFS_DATE && $past(RST_N) |->
      REG_RDATA inside {[8'h01:8'h31]})
      else $error("date left its range");
   trim_clear_a: assert property (
      POWERON_FLAG && REG_RADDR == rtc_pkg::OFS_TRIM ##1
      REG_RADDR == rtc_pkg::OFS_TRIM |=> REG_RDATA == 8'h00)
      else $error("trim not cleared");
   hit_cause_a: assert property (
      WALARM_HIT |-> $past(WEEKLY_ALARM_ENABLE, ALARM_DELAY_CYC) &&
      WALARM_DAYS != 7'h00 ##1 !WALARM_HIT)
      else $error("alarm pulse wrong");
   tick_len_a: assert property (
      SEC_TICK |-> xcnt >= 17'd32630 && xcnt <= 17'd32900)
      else $error("second length wrong");
   cover property (DAY_CARRY && REG_RADDR == rtc_pkg::OFS_DATE);
   cover property (WALARM_HIT);
   cover property (POWERON_FLAG && REG_RADDR == rtc_pkg::OFS_TRIM);
endmodule // rtc_cal_trim_props
bind rtc_cal_trim rtc_cal_trim_props #(.ALARM_DELAY_CYC(ALARM_DELAY_CYC))
   rtc_cal_trim_props_inst (.CLK(CLK), .RST_N(RST_N), .XTAL_CLK(XTAL_CLK),
   .REG_REQ(REG_REQ), .REG_RADDR(REG_RADDR), .REG_RDATA(REG_RDATA),
   .POWERON_FLAG(POWERON_FLAG), .DIV_CLEAR(DIV_CLEAR), .DAY_CARRY(DAY_CARRY),
   .WEEKLY_ALARM_ENABLE(WEEKLY_ALARM_ENABLE), .WALARM_DAYS(WALARM_DAYS), .SEC_TICK(SEC_TICK),
   .WALARM_HIT(WALARM_HIT));

// [bench/rtc_host.sv]
// Purpose: Host side of the register port: writes and reads bytes.
// Assumes: Requests change 1 ns after a rising clock edge.
// Notes:   Released write lines wander instead of holding old values.
`timescale 1ns/1ns
module rtc_host (
   input  wire logic         clk,     // System clock.
   output rtc_pkg::rtc_req_s req,     // Write request.
   output logic [3:0]        raddr,   // Read index.
   input  wire logic [7:0]   rdata    // Read data.
);
   // Idle lines at time zero.
   initial begin
      req = '{wr: 1'b0, addr: 4'h0, data: 8'h00};
      raddr = 4'h0;
   end
   // One write, held for exactly one sampling edge.
   task automatic wr(input logic [3:0] a, input logic [7:0] dt);
      @(posedge clk);
      #1 req = '{wr: 1'b1, addr: a, data: dt};
      @(posedge clk);
      #1 req = '{wr: 1'b0, addr: ~a, data: ~dt};
   endtask
   // One read; the index stays put.
   task automatic rd(input logic [3:0] a, output logic [7:0] dt);
      @(posedge clk);
      #1 raddr = a;
      @(posedge clk);
      #1 dt = rdata;
   endtask
endmodule // rtc_host

// [bench/rtc_calendar_trim_alarm_regs_test.sv]
// Purpose: Self-checking bench of the calendar, trim and alarm block.
// Assumes: 100 MHz clock, 160 ns crystal, short alarm delay.
// Notes:   An integer calendar model gives the expected calendar values after each setcal and carry; etab gives the register read-backs.
`timescale 1ns/1ns
module rtc_calendar_trim_alarm_regs_test;
   localparam int ADC = 4;                      // Short alarm delay.
   logic clk, rst_n, xtal, poweron_flag, div_clear, day_carry, weekly_alarm_enable;
   logic              sec_tick, walarm_hit;     // Block pulses.
   logic [6:0]        walarm_days;              // Alarm day mask.
   logic [7:0]        rdata;                    // Read data.
   logic [3:0]        raddr;                    // Read index.
   rtc_pkg::rtc_req_s req;                      // Write request.
   rtc_pkg::rtc_tod_s tod;                      // Time of day.
   int n_fail, n_compared, wd, d, m, c, y, got; // Counters and model.
   logic [7:0] wtab [7] = '{8'hf6, 8'he5, 8'he4, 8'h57, 8'h45, 8'hd9, 8'he3};
   logic [7:0] etab [7] = '{8'h06, 8'h25, 8'h84, 8'h57, 8'h45, 8'h59, 8'h23};
   logic [3:0] atab [3] = '{4'h3, 4'h4, 4'h6};  // Index held at carries.
   int ctab [4][3] = '{'{2, 0, 28}, '{2, 96, 29}, '{12, 99, 31}, '{2, 23, 28}};
   rtc_cal_trim #(.ALARM_DELAY_CYC(ADC)) rtc_cal_trim_inst (.CLK(clk),
      .RST_N(rst_n), .XTAL_CLK(xtal), .REG_REQ(req), .REG_RADDR(raddr),
      .REG_RDATA(rdata), .POWERON_FLAG(poweron_flag), .DIV_CLEAR(div_clear),
      .DAY_CARRY(day_carry), .TOD(tod), .WEEKLY_ALARM_ENABLE(weekly_alarm_enable),
      .WALARM_DAYS(walarm_days), .SEC_TICK(sec_tick),
      .WALARM_HIT(walarm_hit));
   rtc_host rtc_host_inst (.clk(clk), .req(req), .raddr(raddr),
      .rdata(rdata));
   // ***************************************************************
   // Clocks, model and checking tasks
   // ***************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      xtal = 1'b0;
      #3;
      forever #80 xtal = ~xtal;
   end
   function automatic logic [7:0] i2b(input int x);
      return 8'((x / 10) * 16 + x % 10);
   endfunction
   function automatic int last_day(input int mo, input int yr);
      if (mo == 2) return (yr % 4 == 0) ? 29 : 28;
      return (mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] r;
      rtc_host_inst.rd(a, r);
      chk(r, e);
   endtask
   task automatic setcal(input int w, dd, mm, cc, yy);
      wd = w; d = dd; m = mm; c = cc; y = yy;
      rtc_host_inst.wr(rtc_pkg::OFS_WEEKDAY, i2b(wd));
      rtc_host_inst.wr(rtc_pkg::OFS_DATE, i2b(d));
      rtc_host_inst.wr(rtc_pkg::OFS_MONTH, i2b(m) | {c[0], 7'h00});
      rtc_host_inst.wr(rtc_pkg::OFS_YEAR, i2b(y));
   endtask
   task automatic cmp_all();
      rdc(rtc_pkg::OFS_WEEKDAY, i2b(wd));
      rdc(rtc_pkg::OFS_DATE, i2b(d));
      rdc(rtc_pkg::OFS_MONTH, i2b(m) | {c[0], 7'h00});
      rdc(rtc_pkg::OFS_YEAR, i2b(y));
   endtask
   // One day carry, read index held; the model steps.
   task automatic carry(input logic [3:0] a);
      logic [7:0] r;
      rtc_host_inst.rd(a, r);
      day_carry = 1'b1;
      @(posedge clk);
      #1 day_carry = 1'b0;
      wd = (wd >= 6) ? 0 : wd + 1;
      if (d < last_day(m, y)) d++;
      else begin
         d = 1;
         if (m < 12) m++;
         else begin
            m = 1;
            c = (y == 99) ? 1 - c : c;
            y = (y + 1) % 100;
         end
      end
   endtask
   // Sets the time of day; finds the alarm pulse cycle.
   task automatic alarm(input logic [5:0] h, input int e);
      tod.min = 7'h59;
      tod.hour = h;
      got = 0;
      for (int k = 1; k <= 12; k++) begin
         @(posedge clk);
         #1 if (walarm_hit === 1'b1 && got == 0) got = k;
      end
      chk(8'(got), 8'(e));
      tod.min = 7'h00;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic final_report();
      $display("compared %0d, wrong %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      #300_000;
      n_fail++;
      final_report();
   end
   // ***************************************************************
   // Test sequence
   // ***************************************************************
   initial begin
      n_fail = 0; n_compared = 0; rst_n = 1'b0; poweron_flag = 1'b0;
      div_clear = 1'b0; day_carry = 1'b0; weekly_alarm_enable = 1'b0;
      walarm_days = 7'h00;
      tod = '{sec: 7'h00, min: 7'h00, hour: 6'h00};
      void'($urandom(96391));
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      div_clear = 1'b1;
      @(posedge clk);
      #1 div_clear = 1'b0;
      rdc(rtc_pkg::OFS_TRIM, 8'h00);
      rdc(4'hf, 8'h00);
      for (int i = 0; i < 7; i++) begin
         rtc_host_inst.wr(4'(i + 3), wtab[i]);
         rdc(4'(i + 3), etab[i]);
      end
      $display("test registers done");
      setcal(5, 27, 2, 0, 23);
      for (int i = 0; i < 9; i++) begin
         carry(atab[i % 3]);
         cmp_all();
      end
      for (int i = 1; i <= 12; i++) begin
         got = $urandom_range(99);
         setcal($urandom_range(6), last_day(i, got), i, got % 2, got);
         carry(atab[i % 3]);
         cmp_all();
      end
      for (int i = 0; i < 4; i++) begin
         setcal(6, ctab[i][2], ctab[i][0], 1, ctab[i][1]);
         carry(rtc_pkg::OFS_YEAR);
         cmp_all();
      end
      $display("test calendar done");
      rtc_host_inst.wr(rtc_pkg::OFS_TRIM, 8'h07);
      rdc(rtc_pkg::OFS_TRIM, 8'h07);
      poweron_flag = 1'b1;
      rdc(rtc_pkg::OFS_TRIM, 8'h00);
      poweron_flag = 1'b0;
      rtc_host_inst.wr(rtc_pkg::OFS_AMIN, 8'h59);
      rtc_host_inst.wr(rtc_pkg::OFS_AHOUR, 8'h23);
      weekly_alarm_enable = 1'b1;
      walarm_days = 7'(1 << wd);
      alarm(6'h23, ADC + 1);
      alarm(6'h03, 0);
      walarm_days = ~walarm_days;
      alarm(6'h23, 0);
      chk(8'(sec_tick), 8'h00);
      $display("test trim and alarm done");
      final_report();
   end
endmodule // rtc_calendar_trim_alarm_regs_test
